// ==== inc/eic_defs.vh ====
`ifndef EIC_DEFS_VH
`define EIC_DEFS_VH

// ****************************************************************
// register word indices (byte address = 4 * index)
// ****************************************************************
`define EIC_IDX_CTRL 6'h00
`define EIC_IDX_STATUS 6'h01
`define EIC_IDX_CLEAR 6'h02
`define EIC_IDX_ENABLE 6'h03
`define EIC_IDX_STATE 6'h04

// ****************************************************************
// control register field positions (channel 0 = pin 1)
// ****************************************************************
`define EIC_PRIO_LSB 6
`define EIC_EN_LSB 3
`define EIC_FLAG_LSB 0
`define EIC_CTRL_W 8

// ****************************************************************
// status / enable / clear layout
// ****************************************************************
`define EIC_ST_EVENT_LSB 0
`define EIC_ST_OVR_LSB 2
`define EIC_ST_W 4

// ****************************************************************
// reset values
// ****************************************************************
`define EIC_PRIO_RST 2'h3
`define EIC_EN_RST 2'h0
`define EIC_FLAG_RST 2'h0
`define EIC_ST_RST 4'h0
`define EIC_IE_RST 4'h0
`define EIC_SYNC_RST 2'h0
`define EIC_RDATA_RST 32'h00000000

`endif

// ==== logic/eic_ctrl.v ====
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

`include "eic_defs.vh"

// Behaviour
// - bits 7,6 select high or low priority
// - bits 4,3 enable each pin's request
// - pin event sets flag; only software clears
// - flag bit 1 zero means no event
// - bits 5,2 read zero, writes ignored
// - reset: priorities one, enables and flags zero

module eic_ctrl (
  input wire i_clock,
  input wire i_resetn,
  input wire i_external_interrupt_pin_1,
  input wire i_external_interrupt_pin_2,
  input wire [7:0] i_address,
  input wire i_read,
  input wire i_write,
  input wire [31:0] i_writedata,
  input wire [3:0] i_byteenable,
  output wire [31:0] o_readdata,
  output wire o_waitrequest,
  output wire o_req_high,
  output wire o_req_low,
  output wire o_irq
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  wire [1:0] pin_level;
  wire [1:0] pin_rise;

  eic_pin_sync eic_pin_sync_inst (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_pin({i_external_interrupt_pin_2, i_external_interrupt_pin_1}),
    .o_level(pin_level),
    .o_rise(pin_rise)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  localparam [1:0] BUS_IDLE = 2'h1;
  localparam [1:0] BUS_ANSWER = 2'h2;

  reg [1:0] prio_r;
  reg [1:0] en_r;
  reg [1:0] flag_r;
  reg [3:0] st_r;
  reg [3:0] ie_r;
  reg [1:0] bus_state_r;
  reg [31:0] rdata_r;
  reg req_high_r;
  reg req_low_r;
  reg irq_r;

  wire [1:0] prio_nxt;
  wire [1:0] en_nxt;
  wire [1:0] flag_nxt;
  wire [3:0] st_nxt;
  wire [3:0] ie_nxt;
  reg [1:0] bus_state_nxt;
  reg [31:0] rdata_nxt;
  wire req_high_nxt;
  wire req_low_nxt;
  wire irq_nxt;

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // one wait cycle on every access: the answer comes from registers,
  // so read data is settled a full cycle before the master takes it
  wire bus_req;
  wire bus_wait;
  wire bus_go;
  wire wr_go;

  assign bus_req = i_read | i_write;
  assign bus_wait = bus_state_r[0];
  assign bus_go = bus_req & ~bus_wait;
  assign wr_go = bus_go & i_write;

  // idle holds waitrequest high; answer lowers it for one cycle
  always @* begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      BUS_IDLE: begin
        if (bus_req) begin
          bus_state_nxt = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        bus_state_nxt = BUS_IDLE;
      end
      default: begin
        // a stray code falls back to idle rather than lock the bus
        bus_state_nxt = BUS_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // register decode
  // ****************************************************************
  wire [5:0] word_idx;
  wire sel_ctrl;
  wire sel_clear;
  wire sel_enable;
  wire ctrl_wr;
  wire clear_wr;
  wire enable_wr;
  wire [1:0] wr_prio;
  wire [1:0] wr_en;
  wire [1:0] wr_flag;
  wire [3:0] wr_clear;

  assign word_idx = i_address[7:2];

  assign sel_ctrl = (word_idx == `EIC_IDX_CTRL);
  assign sel_clear = (word_idx == `EIC_IDX_CLEAR);
  assign sel_enable = (word_idx == `EIC_IDX_ENABLE);

  // only byte lane 0 carries data; other lanes are ignored
  assign ctrl_wr = wr_go & sel_ctrl & i_byteenable[0];
  assign clear_wr = wr_go & sel_clear & i_byteenable[0];
  assign enable_wr = wr_go & sel_enable & i_byteenable[0];

  // write data split into the fields of the control layout
  assign wr_prio = i_writedata[`EIC_PRIO_LSB+1:`EIC_PRIO_LSB];
  assign wr_en = i_writedata[`EIC_EN_LSB+1:`EIC_EN_LSB];
  assign wr_flag = i_writedata[`EIC_FLAG_LSB+1:`EIC_FLAG_LSB];
  // clear strobes per status bit, idle unless the clear word is hit
  assign wr_clear = {`EIC_ST_W{clear_wr}} & i_writedata[`EIC_ST_W-1:0];

  // ****************************************************************
  // per-channel control, flag and status logic
  // ****************************************************************
  wire [1:0] chan_high;
  wire [1:0] chan_low;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_chan
      // priority and enable are plain read/write fields
      assign prio_nxt[g] = ctrl_wr ? wr_prio[g] : prio_r[g];
      assign en_nxt[g] = ctrl_wr ? wr_en[g] : en_r[g];

      // event sets regardless of enable; a write in the same cycle
      // cannot drop it, so the set wins
      assign flag_nxt[g] = pin_rise[g] |
        (ctrl_wr ? wr_flag[g] : flag_r[g]);

      // sticky system status: event and overrun (event on a set flag)
      assign st_nxt[`EIC_ST_EVENT_LSB + g] = pin_rise[g] |
        (st_r[`EIC_ST_EVENT_LSB + g] & ~wr_clear[`EIC_ST_EVENT_LSB + g]);
      assign st_nxt[`EIC_ST_OVR_LSB + g] = (pin_rise[g] & flag_r[g]) |
        (st_r[`EIC_ST_OVR_LSB + g] & ~wr_clear[`EIC_ST_OVR_LSB + g]);

      // a channel requests only with flag and enable both set,
      // on the level its priority bit picks
      assign chan_high[g] = flag_nxt[g] & en_nxt[g] &
        prio_nxt[g];
      assign chan_low[g] = flag_nxt[g] & en_nxt[g] &
        ~prio_nxt[g];
    end
  endgenerate

  assign ie_nxt = enable_wr ? i_writedata[`EIC_ST_W-1:0] : ie_r;

  // ****************************************************************
  // requests toward the processor
  // ****************************************************************
  // computed from next values so the outputs leave flip-flops and
  // still follow a flag or write without an extra cycle of lag
  assign req_high_nxt = |chan_high;
  assign req_low_nxt = |chan_low;
  assign irq_nxt = |(st_nxt & ie_nxt);

  // ****************************************************************
  // read path
  // ****************************************************************
  wire [7:0] ctrl_view;
  wire [31:0] view_ctrl;
  wire [31:0] view_status;
  wire [31:0] view_enable;
  wire [31:0] view_state;

  // unimplemented positions are hard zeros, never stored
  assign ctrl_view = {prio_r[1], prio_r[0], 1'b0, en_r[1], en_r[0],
    1'b0, flag_r[1], flag_r[0]};
  assign view_ctrl = {24'h000000, ctrl_view};
  assign view_status = {28'h0000000, st_r};
  assign view_enable = {28'h0000000, ie_r};
  assign view_state = {28'h0000000, req_low_r, req_high_r, pin_level};

  // loaded as the request is first seen, so the word is settled
  // for the whole cycle in which waitrequest is low
  always @* begin
    rdata_nxt = rdata_r;
    if (i_read && bus_wait) begin
      case (word_idx)
        `EIC_IDX_CTRL: begin
          rdata_nxt = view_ctrl;
        end
        `EIC_IDX_STATUS: begin
          rdata_nxt = view_status;
        end
        `EIC_IDX_ENABLE: begin
          rdata_nxt = view_enable;
        end
        `EIC_IDX_STATE: begin
          rdata_nxt = view_state;
        end
        default: begin
          // clear register is write-only; unmapped reads give zero
          rdata_nxt = `EIC_RDATA_RST;
        end
      endcase
    end
  end

  // ****************************************************************
  // control fields
  // ****************************************************************
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      prio_r <= `EIC_PRIO_RST;
      en_r <= `EIC_EN_RST;
    end else begin
      prio_r <= prio_nxt;
      en_r <= en_nxt;
    end
  end

  // ****************************************************************
  // event flags
  // ****************************************************************
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_r <= `EIC_FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // ****************************************************************
  // status and interrupt enable
  // ****************************************************************
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= `EIC_ST_RST;
      ie_r <= `EIC_IE_RST;
    end else begin
      st_r <= st_nxt;
      ie_r <= ie_nxt;
    end
  end

  // ****************************************************************
  // bus handshake and read data
  // ****************************************************************
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      bus_state_r <= BUS_IDLE;
      rdata_r <= `EIC_RDATA_RST;
    end else begin
      bus_state_r <= bus_state_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // request levels
  // ****************************************************************
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      req_high_r <= 1'b0;
      req_low_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      req_high_r <= req_high_nxt;
      req_low_r <= req_low_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_readdata = rdata_r;
  assign o_waitrequest = bus_state_r[0];
  assign o_req_high = req_high_r;
  assign o_req_low = req_low_r;
  assign o_irq = irq_r;

endmodule

`default_nettype wire

// ==== logic/eic_ctrl_end.v ====
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ==== logic/eic_pin_sync.v ====
`timescale 1ns/1ns
`default_nettype none

module eic_pin_sync (
  input wire i_clock,
  input wire i_resetn,
  input wire [1:0] i_pin,
  output wire [1:0] o_level,
  output wire [1:0] o_rise
);

  // ****************************************************************
  // two-flop synchroniser and rising-edge detect, one per pin
  // ****************************************************************
  reg [1:0] meta_r;
  reg [1:0] sync_r;
  reg [1:0] prev_r;
  reg [1:0] rise_r;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin
      // meta_r feeds sync_r only; pins are asynchronous to i_clock
      always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
          prev_r[g] <= 1'b0;
          rise_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= i_pin[g];
          sync_r[g] <= meta_r[g];
          prev_r[g] <= sync_r[g];
          rise_r[g] <= sync_r[g] & ~prev_r[g];
        end
      end
    end
  endgenerate

  assign o_level = sync_r;
  assign o_rise = rise_r;

endmodule

`default_nettype wire

// ==== tb/eic_ctrl_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// bench
// ****
module eic_ctrl_bench;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] got;
  logic [1:0] fire = 2'h0;
  logic [3:0] be = 4'hF;
  wire [1:0] pin;
  wire [31:0] rdat;
  wire wreq, req_h, req_l, irq;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #25 i_clock = ~i_clock;
  eic_pin_src eic_pin_src_inst (.i_clock(i_clock), .i_fire(fire), .o_pin(pin));
  eic_ctrl eic_ctrl_inst (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_external_interrupt_pin_1(pin[0]), .i_external_interrupt_pin_2(pin[1]),
    .i_address(adr), .i_read(rd), .i_write(wr), .i_writedata(wdat),
    .i_byteenable(be), .o_readdata(rdat), .o_waitrequest(wreq),
    .o_req_high(req_h), .o_req_low(req_l), .o_irq(irq));
  task conclude;
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard; whole run is well under this
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task acc(input logic w, input logic [5:0] i, input logic [31:0] v);
    adr <= {i, 2'b00};
    wdat <= v;
    rd <= !w;
    wr <= w;
    do @(posedge i_clock); while (wreq !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge i_clock);
  endtask
  task rdc(input logic [5:0] i, input logic [31:0] e);
    acc(1'b0, i, 32'h0);
    chk(got, e);
  endtask
  task pulse(input logic [1:0] m);
    fire <= m;
    @(posedge i_clock);
    fire <= 2'h0;
    repeat (10) @(posedge i_clock);
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(posedge i_clock);
    rdc(6'h00, 32'hC0);
    rdc(6'h01, 32'h0);
    rdc(6'h03, 32'h0);
    acc(1'b1, 6'h00, 32'hFF);
    rdc(6'h00, 32'hDB);
    chk(req_h, 1'b1);
    chk(req_l, 1'b0);
    acc(1'b1, 6'h00, 32'h18);
    acc(1'b1, 6'h02, 32'h0F);
    chk(req_h, 1'b0);
    pulse(2'h1);
    rdc(6'h00, 32'h19);
    chk(req_l, 1'b1);
    acc(1'b1, 6'h00, 32'h01);
    chk(req_l, 1'b0);
    pulse(2'h2);
    rdc(6'h00, 32'h03);
    acc(1'b1, 6'h03, 32'h0F);
    chk(irq, 1'b1);
    pulse(2'h1);
    rdc(6'h01, 32'h07);
    rdc(6'h00, 32'h03);
    acc(1'b1, 6'h03, 32'h00);
    chk(irq, 1'b0);
    acc(1'b1, 6'h02, 32'h07);
    rdc(6'h01, 32'h00);
    acc(1'b1, 6'h00, 32'h01);
    rdc(6'h00, 32'h01);
    be <= 4'h0;
    acc(1'b1, 6'h00, 32'hFF);
    be <= 4'hF;
    rdc(6'h00, 32'h01);
    rdc(6'h04, 32'h0);
    rdc(6'h02, 32'h0);
    acc(1'b1, 6'h07, 32'hFF);
    rdc(6'h07, 32'h0);
    acc(1'b1, 6'h00, 32'h1B);
    chk(req_l, 1'b1);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(posedge i_clock);
    chk(req_l, 1'b0);
    rdc(6'h00, 32'hC0);
    conclude();
  end
endmodule
`default_nettype wire

// ==== tb/eic_ctrl_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// bus and request checks
// ****
module eic_ctrl_properties (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_req_high,
  input wire logic o_req_low,
  input wire logic o_irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  wire logic [7:0] d;
  wire logic rc;
  wire logic [5:0] ix;
  assign d = o_readdata[7:0];
  assign rc = i_read && !o_waitrequest;
  assign ix = i_address[7:2];
  property p_one;
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("wait not one cycle");
  property p_back;
    !o_waitrequest |=> o_waitrequest;
  endproperty
  a_back: assert property (p_back) else $error("wait low too long");
  property p_idle;
    !i_read && !i_write |=> o_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("answer with no request");
  property p_gap;
    rc && ix == 6'h00 |-> d[5] == 1'b0 && d[2] == 1'b0;
  endproperty
  a_gap: assert property (p_gap) else $error("gap bit set");
  property p_clr;
    rc && ix == 6'h02 |-> o_readdata == 32'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear reg not zero");
  property p_req;
    rc && ix == 6'h00 |-> $past(o_req_high) == |(d[1:0] & d[4:3] & d[7:6])
      && $past(o_req_low) == |(d[1:0] & d[4:3] & ~d[7:6]);
  endproperty
  a_req: assert property (p_req) else $error("request mismatch");
  property p_st;
    rc && ix == 6'h04 |-> o_readdata[3:2] == $past({o_req_low, o_req_high});
  endproperty
  a_st: assert property (p_st) else $error("state mismatch");
  property p_rst;
    $rose(i_resetn) |-> o_waitrequest && !o_req_high && !o_req_low && !o_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset out");
endmodule
bind eic_ctrl eic_ctrl_properties eic_ctrl_properties_inst (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_address(i_address),
  .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .o_req_high(o_req_high),
  .o_req_low(o_req_low), .o_irq(o_irq));
`default_nettype wire

// ==== tb/eic_pin_src.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// pin sources, pulse three clocks
// ****
module eic_pin_src (
  input wire logic i_clock,
  input wire logic [1:0] i_fire,
  output logic [1:0] o_pin
);
  logic [2:0] a_r = 3'h0;
  logic [2:0] b_r = 3'h0;
  // long enough for the two-flop sync to see it
  always @(posedge i_clock) begin
    a_r <= {a_r[1:0], i_fire[0]};
    b_r <= {b_r[1:0], i_fire[1]};
  end
  assign o_pin = {|b_r, |a_r};
endmodule
`default_nettype wire
